// *** pp_uart_logical_device_config.sv ***
// Configuration bank for the parallel port and first serial port logical devices
// How it works
// - The parallel port mode field holds one of seven three-bit codes, printer mode by default.
// - A four-bit ECP FIFO threshold field resets to 0111 and the whole mode register to 3c.
// - With the irq style bit set the request is pulsed low for a fixed time, then released.
// - With the style bit clear the request follows the acknowledge pin, or is level in FIFO modes.
// - The style bit is ignored in printer mode and in standard bidirectional mode.
// - With timeout select clear the EPP timeout flag clears only on a write of one to it.
// - With timeout select set the EPP timeout flag clears at the end of a status read.
// - Bit 0 of the first serial port mode register enables MIDI, off by default.
// - Bit 1 of the first serial port mode register enables high speed, off by default.
// - Reserved bits 6 to 2 of the first serial port mode register hold zero.
// - Share clear keeps the two serial interrupts apart, share set joins them.
// - With share set, both serial interrupt outputs rise when either port requests.
// - Only the hard reset restores the mode and mask registers; a soft reset leaves them alone.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps
`include "pp_cfg_map.svh"
module pp_uart_logical_device_config
   import pp_cfg_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic soft_rst,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic ack_n_pin,
   input wire logic ecp_fifo_active,
   input wire logic ecp_irq_req,
   input wire logic epp_timeout_set,
   input wire logic sp1_irq_req,
   input wire logic sp2_irq_req,
   output pp_mode_t pp_mode,
   output logic [3:0] ecp_fifo_threshold,
   output logic parallel_irq_style,
   output logic timeout_clear_select,
   output logic midi_enable,
   output logic high_speed_enable,
   output logic share_irq,
   output logic epp_timeout_flag,
   output logic pp_irq_out,
   output logic pp_irq_oe,
   output logic sp1_irq_out,
   output logic sp2_irq_out,
   output logic irq
);

   // ****************************************************************
   // Decode
   // ****************************************************************
   logic [7:0] ldn;
   logic sel_pp;
   logic sel_sp1;
   logic wr_pp_mode;
   logic wr_pp_second;
   logic wr_sp1_mode;
   logic wr_epp_status;
   logic rd_epp_status;
   logic rd_int_status;

   assign sel_pp = (ldn == `LDN_PARALLEL);
   assign sel_sp1 = (ldn == `LDN_FIRST_SERIAL);
   assign wr_pp_mode = wr && sel_pp && (addr == `OFS_MODE);
   assign wr_pp_second = wr && sel_pp && (addr == `OFS_MODE_SECOND);
   assign wr_sp1_mode = wr && sel_sp1 && (addr == `OFS_MODE);
   assign wr_epp_status = wr && (addr == `OFS_EPP_STATUS);
   assign rd_epp_status = rd && (addr == `OFS_EPP_STATUS);
   assign rd_int_status = rd && (addr == `OFS_INT_STATUS);

   // ****************************************************************
   // Logical device select
   // ****************************************************************
   // The device select is ordinary config state, so a soft reset returns it
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ldn <= `RST_LDN;
      end else if (soft_rst) begin
         ldn <= `RST_LDN;
      end else if (wr && (addr == `OFS_LDN)) begin
         ldn <= wdata;
      end
   end

   // ****************************************************************
   // Vendor registers
   // ****************************************************************
   // hard reset only
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pp_mode <= 3'(`RST_MODE >> `PP_MODE_LSB);
         ecp_fifo_threshold <= 4'(`RST_MODE >> `PP_THR_LSB);
         parallel_irq_style <= 1'(`RST_MODE >> `PP_STYLE_BIT);
      end else if (wr_pp_mode) begin
         pp_mode <= wdata[`PP_MODE_MSB:`PP_MODE_LSB];
         ecp_fifo_threshold <= wdata[`PP_THR_MSB:`PP_THR_LSB];
         parallel_irq_style <= wdata[`PP_STYLE_BIT];
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         timeout_clear_select <= 1'(`RST_MODE_SECOND >> `PP_TOSEL_BIT);
      end else if (wr_pp_second) begin
         timeout_clear_select <= wdata[`PP_TOSEL_BIT];
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         midi_enable <= 1'(`RST_SERIAL_MODE >> `SP_MIDI_BIT);
         high_speed_enable <= 1'(`RST_SERIAL_MODE >> `SP_HS_BIT);
         share_irq <= 1'(`RST_SERIAL_MODE >> `SP_SHARE_BIT);
      end else if (wr_sp1_mode) begin
         midi_enable <= wdata[`SP_MIDI_BIT];
         high_speed_enable <= wdata[`SP_HS_BIT];
         share_irq <= wdata[`SP_SHARE_BIT];
      end
   end

   // ****************************************************************
   // EPP timeout flag
   // ****************************************************************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         epp_timeout_flag <= 1'b0;
      end else if (epp_timeout_set) begin
         // A new timeout beats a clear in the same cycle
         epp_timeout_flag <= 1'b1;
      end else if (!timeout_clear_select && wr_epp_status && wdata[`EPP_EPP_TIMEOUT_FLAG_BIT]) begin
         epp_timeout_flag <= 1'b0;
      end else if (timeout_clear_select && rd_epp_status) begin
         epp_timeout_flag <= 1'b0;
      end
   end

   // ****************************************************************
   // Parallel port interrupt
   // ****************************************************************
   logic ack_n_stable;
   logic ack_n_prev;
   logic ecp_req_prev;
   logic style_active;
   logic pp_level;
   logic pp_event;
   pulse_state_t pulse_state;
   pulse_cnt_t pulse_cnt;

   sync_filter u_ack_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .din(ack_n_pin),
      .dout(ack_n_stable)
   );

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ack_n_prev <= 1'b1;
         ecp_req_prev <= 1'b0;
      end else begin
         ack_n_prev <= ack_n_stable;
         ecp_req_prev <= ecp_irq_req;
      end
   end

   assign style_active = parallel_irq_style &&
                         (pp_mode != `PP_MODE_PRINTER) && (pp_mode != `PP_MODE_SPP);
   assign pp_level = ecp_fifo_active ? ecp_irq_req : ack_n_stable;
   assign pp_event = ecp_fifo_active ? (ecp_irq_req && !ecp_req_prev)
                                     : (!ack_n_stable && ack_n_prev);

   // Pulse length is fixed; back-to-back events inside a pulse merge into it
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pulse_state <= PULSE_IDLE;
         pulse_cnt <= 4'h0;
         pp_irq_out <= 1'b1;
         pp_irq_oe <= 1'b1;
      end else if (!style_active) begin
         pulse_state <= PULSE_IDLE;
         pulse_cnt <= 4'h0;
         pp_irq_out <= pp_level;
         pp_irq_oe <= 1'b1;
      end else begin
         case (pulse_state)
            PULSE_IDLE: begin
               pp_irq_out <= 1'b0;
               if (pp_event) begin
                  pulse_state <= PULSE_LOW;
                  pulse_cnt <= 4'(`PP_PULSE_CYC - 1);
                  pp_irq_oe <= 1'b1;
               end else begin
                  pp_irq_oe <= 1'b0;
               end
            end
            PULSE_LOW: begin
               pp_irq_out <= 1'b0;
               if (pulse_cnt == 4'h0) begin
                  pulse_state <= PULSE_IDLE;
                  pp_irq_oe <= 1'b0;
               end else begin
                  pulse_cnt <= pulse_cnt - 4'h1;
               end
            end
            default: begin
               pulse_state <= PULSE_IDLE;
               pp_irq_oe <= 1'b0;
               pp_irq_out <= 1'b0;
            end
         endcase
      end
   end

   // ****************************************************************
   // Serial port interrupt routing
   // ****************************************************************
   // software leaves one port unrouted
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sp1_irq_out <= 1'b0;
         sp2_irq_out <= 1'b0;
      end else begin
         sp1_irq_out <= share_irq ? (sp1_irq_req || sp2_irq_req) : sp1_irq_req;
         sp2_irq_out <= share_irq ? (sp1_irq_req || sp2_irq_req) : sp2_irq_req;
      end
   end

   // ****************************************************************
   // Event status, mask and interrupt
   // ****************************************************************
   logic [2:0] int_status;
   logic [2:0] int_mask;
   logic [2:0] int_set;
   logic sp1_req_prev;
   logic sp2_req_prev;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sp1_req_prev <= 1'b0;
         sp2_req_prev <= 1'b0;
      end else begin
         sp1_req_prev <= sp1_irq_req;
         sp2_req_prev <= sp2_irq_req;
      end
   end

   assign int_set[`INT_EPP_TIMEOUT_FLAG_BIT] = epp_timeout_set;
   assign int_set[`INT_SP1_BIT] = sp1_irq_req && !sp1_req_prev;
   assign int_set[`INT_SP2_BIT] = sp2_irq_req && !sp2_req_prev;

   // Set beats the clear-on-read, so an event in the read cycle survives
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         int_status <= 3'h0;
      end else if (soft_rst) begin
         int_status <= int_set;
      end else if (rd_int_status) begin
         int_status <= int_set;
      end else begin
         int_status <= int_status | int_set;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         int_mask <= `RST_INT_MASK;
      end else if (wr && (addr == `OFS_INT_MASK)) begin
         int_mask <= wdata[2:0];
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(int_status & int_mask);
      end
   end

   // ****************************************************************
   // Read data
   // ****************************************************************
   logic [7:0] next_rdata;

   always_comb begin
      next_rdata = 8'h00;
      if (rd) begin
         case (addr)
            `OFS_LDN: next_rdata = ldn;
            `OFS_MODE: begin
               if (sel_pp) begin
                  next_rdata = {parallel_irq_style, ecp_fifo_threshold, pp_mode};
               end else if (sel_sp1) begin
                  next_rdata = {share_irq, 5'h00, high_speed_enable, midi_enable};
               end
            end
            `OFS_MODE_SECOND: begin
               if (sel_pp) begin
                  next_rdata = {3'h0, timeout_clear_select, 4'h0};
               end
            end
            `OFS_INT_STATUS: next_rdata = {5'h00, int_status};
            `OFS_INT_MASK: next_rdata = {5'h00, int_mask};
            `OFS_EPP_STATUS: next_rdata = {7'h00, epp_timeout_flag};
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdata <= 8'h00;
      end else begin
         rdata <= next_rdata;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence pulse_start;
      style_active && pulse_state == PULSE_IDLE && pp_event;
   endsequence

   sequence pulse_held;
      (pp_irq_oe && !pp_irq_out)[*8];
   endsequence

   a_mode_write_store: assert property (
      wr_pp_mode |=> pp_mode == $past(wdata[2:0]))
      else $error("mode field did not take written code");

   a_pulse_low_hold: assert property (
      pulse_start ##1 style_active[*8] ##1 style_active[*2]
      |-> pp_irq_oe && !pp_irq_out ##1 !pp_irq_oe)
      else $error("pulse shape broken");

   a_pulse_low_time: assert property (
      pulse_start and style_active |=> pulse_held)
      else $error("pulse shorter than eight cycles");

   a_pulse_release_hiz: assert property (
      style_active && pulse_state == PULSE_LOW && pulse_cnt == 4'h0 ##1 style_active
      |-> !pp_irq_oe)
      else $error("pulse not released");

   a_follow_ack_pin: assert property (
      !style_active && !ecp_fifo_active |=> pp_irq_oe && pp_irq_out == $past(ack_n_stable))
      else $error("request does not follow acknowledge");

   a_ecp_level_type: assert property (
      !style_active && ecp_fifo_active |=> pp_irq_out == $past(ecp_irq_req))
      else $error("request not level type");

   a_style_ignored_mode: assert property (
      (pp_mode == `PP_MODE_PRINTER || pp_mode == `PP_MODE_SPP) |=> pp_irq_oe)
      else $error("style bit acted in printer or standard mode");

   a_epp_timeout_flag_write_clear: assert property (
      !timeout_clear_select && wr_epp_status && wdata[0] && !epp_timeout_set
      |=> !epp_timeout_flag)
      else $error("write of one did not clear timeout");

   a_epp_timeout_flag_read_keep: assert property (
      !timeout_clear_select && epp_timeout_flag && !wr && !epp_timeout_set
      |=> epp_timeout_flag)
      else $error("timeout cleared without write");

   a_epp_timeout_flag_read_clear: assert property (
      timeout_clear_select && rd_epp_status && !epp_timeout_set
      |=> !epp_timeout_flag && rdata[0] == $past(epp_timeout_flag))
      else $error("status read did not clear timeout");

   a_sp_reserved_zero: assert property (
      rd && sel_sp1 && addr == `OFS_MODE |=> rdata[6:2] == 5'h00)
      else $error("serial reserved bits not zero");

   a_sp_separate_irq: assert property (
      !share_irq |=> sp1_irq_out == $past(sp1_irq_req) && sp2_irq_out == $past(sp2_irq_req))
      else $error("separate serial interrupts mixed");

   a_sp_share_both: assert property (
      share_irq && (sp1_irq_req || sp2_irq_req) |=> sp1_irq_out && sp2_irq_out)
      else $error("shared interrupt not on both outputs");

   a_soft_reset_keep: assert property (
      soft_rst && !wr |=> $stable(pp_mode) && $stable(share_irq) && $stable(timeout_clear_select))
      else $error("soft reset changed vendor registers");

endmodule : pp_uart_logical_device_config

// *** pp_cfg_map.svh ***
// Offsets, field positions, reset values and timing counts of the configuration bank
`ifndef PP_CFG_MAP_SVH
`define PP_CFG_MAP_SVH

// ****************************************************************
// Register indices
// ****************************************************************
`define OFS_LDN 8'h07
`define OFS_MODE 8'hf0
`define OFS_MODE_SECOND 8'hf1
`define OFS_INT_STATUS 8'hf8
`define OFS_INT_MASK 8'hf9
`define OFS_EPP_STATUS 8'hfa

// ****************************************************************
// Logical device numbers
// ****************************************************************
`define LDN_PARALLEL 8'h03
`define LDN_FIRST_SERIAL 8'h04

// ****************************************************************
// Field positions
// ****************************************************************
`define PP_MODE_LSB 0
`define PP_MODE_MSB 2
`define PP_THR_LSB 3
`define PP_THR_MSB 6
`define PP_STYLE_BIT 7
`define PP_TOSEL_BIT 4
`define SP_MIDI_BIT 0
`define SP_HS_BIT 1
`define SP_SHARE_BIT 7
`define EPP_EPP_TIMEOUT_FLAG_BIT 0
`define INT_EPP_TIMEOUT_FLAG_BIT 0
`define INT_SP1_BIT 1
`define INT_SP2_BIT 2

// ****************************************************************
// Mode codes
// ****************************************************************
`define PP_MODE_PRINTER 3'h4
`define PP_MODE_SPP 3'h0
`define PP_MODE_EPP19 3'h1
`define PP_MODE_EPP17 3'h5
`define PP_MODE_ECP 3'h2
`define PP_MODE_ECP_EPP19 3'h3
`define PP_MODE_ECP_EPP17 3'h7

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_MODE 8'h3c
`define RST_MODE_SECOND 8'h00
`define RST_SERIAL_MODE 8'h00
`define RST_LDN 8'h00
`define RST_INT_MASK 3'h0

// ****************************************************************
// Timing
// ****************************************************************
`define REF_CLK_MHZ 100
`define PP_PULSE_NS 100
`define PP_PULSE_CYC ((`PP_PULSE_NS * `REF_CLK_MHZ + 999) / 1000)

`endif

// *** pp_cfg_pkg.sv ***
// Types shared by the configuration bank
package pp_cfg_pkg;
   typedef logic [2:0] pp_mode_t;
   typedef logic [3:0] pulse_cnt_t;
   typedef enum logic {PULSE_IDLE, PULSE_LOW} pulse_state_t;
endpackage : pp_cfg_pkg

// *** sync_filter.sv ***
// Three-stage pin synchroniser that moves only when the last two stages agree
`timescale 1ns/100ps
module sync_filter (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic din,
   output logic dout
);
   logic stage1;
   logic stage2;
   logic stage3;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         stage1 <= 1'b1;
         stage2 <= 1'b1;
         stage3 <= 1'b1;
      end else begin
         stage1 <= din;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // Stage1 may be metastable, so only stage2 and stage3 vote
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         dout <= 1'b1;
      end else if (stage2 == stage3) begin
         dout <= stage3;
      end
   end
endmodule : sync_filter

// *** test_pp_uart_logical_device_config.sv ***
// Self-checking testbench for the parallel and serial port configuration bank
`timescale 1ns/100ps
`include "pp_cfg_map.svh"
`define CHK(nm, e, g) begin \
   n_tests++; \
   if ((g) !== (e)) begin \
      n_fail++; \
      $display("BAD %s exp %h got %h", nm, e, g); \
   end \
end
module test_pp_uart_logical_device_config
   import pp_cfg_pkg::*;
;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic soft_rst = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic rd_q = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic ack_n_pin = 1'b1;
   logic ecp_fifo_active = 1'b0;
   logic ecp_irq_req = 1'b0;
   logic epp_timeout_set = 1'b0;
   logic sp1_irq_req = 1'b0;
   logic sp2_irq_req = 1'b0;
   logic [7:0] rdata;
   pp_mode_t pp_mode;
   logic [3:0] thr;
   logic style, tosel, midi, hs, share, tflag, pout, poe, s1, s2, irq;
   logic [7:0] q_exp[$];
   logic [7:0] q_msk[$];
   logic [7:0] e;
   logic [7:0] m;
   logic [3:0] t;
   pp_mode_t codes[7] = '{3'h4, 3'h0, 3'h1, 3'h5, 3'h2, 3'h3, 3'h7};
   int n_fail = 0;
   int n_tests = 0;
   int cyc = 0;
   int i;
   int k;

   always #5 ref_clk = ~ref_clk;

   pp_uart_logical_device_config dut (
      .ref_clk(ref_clk), .rst(rst), .soft_rst(soft_rst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .ack_n_pin(ack_n_pin),
      .ecp_fifo_active(ecp_fifo_active), .ecp_irq_req(ecp_irq_req),
      .epp_timeout_set(epp_timeout_set), .sp1_irq_req(sp1_irq_req),
      .sp2_irq_req(sp2_irq_req), .pp_mode(pp_mode), .ecp_fifo_threshold(thr),
      .parallel_irq_style(style), .timeout_clear_select(tosel), .midi_enable(midi),
      .high_speed_enable(hs), .share_irq(share), .epp_timeout_flag(tflag),
      .pp_irq_out(pout), .pp_irq_oe(poe), .sp1_irq_out(s1), .sp2_irq_out(s2), .irq(irq)
   );

   // ****************************************************************
   // Bus tasks
   // ****************************************************************
   // Each task but end_sim waits an edge first, so a strobe is never assigned twice in one step
   task wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask : wreg

   task rreg(input logic [7:0] a, input logic [7:0] ex, input logic [7:0] mk);
      q_exp.push_back(ex);
      q_msk.push_back(mk);
      @(posedge ref_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
   endtask : rreg

   task tpulse;
      @(posedge ref_clk);
      epp_timeout_set <= 1'b1;
      @(posedge ref_clk);
      epp_timeout_set <= 1'b0;
   endtask : tpulse

   task idle(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : idle

   task hreset;
      @(posedge ref_clk);
      rst <= 1'b1;
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
   endtask : hreset

   task end_sim;
      $display("tests %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_sim

   // ****************************************************************
   // Read data monitor
   // ****************************************************************
   // Read data stand only in the cycle after the strobe, so look mid-cycle
   always @(posedge ref_clk) rd_q <= rd;
   always @(negedge ref_clk) begin
      if (rd_q) begin
         e = q_exp.pop_front();
         m = q_msk.pop_front();
         `CHK("rdata", e & m, rdata & m)
      end
   end

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         end_sim();
      end
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      k = $urandom(32'h76b7d776);
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      idle(1);
      `CHK("pp_mode", 3'h4, pp_mode)
      `CHK("thr", 4'h7, thr)
      `CHK("serial", 3'h0, {midi, hs, share})
      wreg(`OFS_LDN, `LDN_PARALLEL);
      rreg(`OFS_MODE, 8'h3c, 8'hff);
      rreg(`OFS_MODE_SECOND, 8'h00, 8'hff);
      rreg(8'h55, 8'h00, 8'hff);
      // Mode codes every one
      for (i = 0; i < 7; i++) begin
         t = 4'($urandom);
         wreg(`OFS_MODE, {1'b1, t, codes[i]});
         rreg(`OFS_MODE, {1'b1, t, codes[i]}, 8'hff);
         idle(1);
         `CHK("pp_mode", codes[i], pp_mode)
         `CHK("thr", t, thr)
         `CHK("style", 1'b1, style)
      end
      wreg(`OFS_MODE, 8'h3c);
      // Timeout clear by write
      tpulse();
      idle(1);
      `CHK("tflag", 1'b1, tflag)
      rreg(`OFS_EPP_STATUS, 8'h01, 8'h01);
      wreg(`OFS_EPP_STATUS, 8'h00);
      idle(1);
      `CHK("tflag", 1'b1, tflag)
      wreg(`OFS_EPP_STATUS, 8'h01);
      idle(1);
      `CHK("tflag", 1'b0, tflag)
      // Timeout clear by read
      wreg(`OFS_MODE_SECOND, 8'h10);
      idle(1);
      `CHK("tosel", 1'b1, tosel)
      tpulse();
      rreg(`OFS_EPP_STATUS, 8'h01, 8'h01);
      idle(1);
      `CHK("tflag", 1'b0, tflag)
      // Sticky status, mask and level output
      rreg(`OFS_INT_STATUS, 8'h01, 8'h07);
      rreg(`OFS_INT_STATUS, 8'h00, 8'h07);
      tpulse();
      idle(3);
      `CHK("irq masked", 1'b0, irq)
      rreg(`OFS_INT_STATUS, 8'h01, 8'h07);
      wreg(`OFS_INT_MASK, 8'h01);
      rreg(`OFS_INT_MASK, 8'h01, 8'h07);
      tpulse();
      idle(3);
      `CHK("irq", 1'b1, irq)
      rreg(`OFS_INT_STATUS, 8'h01, 8'h07);
      idle(3);
      `CHK("irq cleared", 1'b0, irq)
      // Serial port bits; reserved bits are not kept
      wreg(`OFS_LDN, `LDN_FIRST_SERIAL);
      t = 4'($urandom);
      wreg(`OFS_MODE, {1'b0, 5'h1f, t[1:0]});
      rreg(`OFS_MODE, {6'h00, t[1:0]}, 8'hff);
      idle(1);
      `CHK("midi hs", t[1:0], {hs, midi})
      @(posedge ref_clk) sp1_irq_req <= 1'b1;
      idle(2);
      `CHK("sp outs", 2'b10, {s1, s2})
      wreg(`OFS_MODE, 8'h80);
      idle(2);
      `CHK("share", 1'b1, share)
      `CHK("sp shared", 2'b11, {s1, s2})
      @(posedge ref_clk) sp1_irq_req <= 1'b0;
      sp2_irq_req <= 1'b1;
      idle(2);
      `CHK("sp shared", 2'b11, {s1, s2})
      rreg(`OFS_INT_STATUS, 8'h06, 8'h07);
      @(posedge ref_clk) sp2_irq_req <= 1'b0;
      // Parallel request follows the pin, or the ECP level
      wreg(`OFS_LDN, `LDN_PARALLEL);
      wreg(`OFS_MODE, 8'h38);
      @(posedge ref_clk) ack_n_pin <= 1'b0;
      idle(8);
      `CHK("pp irq", 2'b10, {poe, pout})
      @(posedge ref_clk) ack_n_pin <= 1'b1;
      idle(8);
      @(posedge ref_clk) ecp_fifo_active <= 1'b1;
      ecp_irq_req <= 1'b1;
      idle(3);
      `CHK("pp level", 2'b11, {poe, pout})
      @(posedge ref_clk) ecp_irq_req <= 1'b0;
      idle(3);
      `CHK("pp level", 2'b10, {poe, pout})
      @(posedge ref_clk) ecp_fifo_active <= 1'b0;
      // Style bit has no effect in printer mode
      wreg(`OFS_MODE, 8'hbc);
      @(posedge ref_clk) ack_n_pin <= 1'b0;
      idle(8);
      `CHK("pp printer", 2'b10, {poe, pout})
      @(posedge ref_clk) ack_n_pin <= 1'b1;
      idle(8);
      // Pulsed style in ECP mode
      wreg(`OFS_MODE, 8'hba);
      idle(2);
      `CHK("pp idle oe", 1'b0, poe)
      @(posedge ref_clk) ack_n_pin <= 1'b0;
      for (i = 0; i < 20 && poe !== 1'b1; i++) idle(1);
      k = 0;
      while (poe === 1'b1 && pout === 1'b0 && k < 30) begin
         k++;
         idle(1);
      end
      `CHK("pulse len", `PP_PULSE_CYC, k)
      @(posedge ref_clk) ack_n_pin <= 1'b1;
      idle(8);
      // Soft reset keeps, hard reset restores
      wreg(`OFS_MODE_SECOND, 8'h10);
      @(posedge ref_clk) soft_rst <= 1'b1;
      @(posedge ref_clk) soft_rst <= 1'b0;
      wreg(`OFS_LDN, `LDN_PARALLEL);
      rreg(`OFS_MODE, 8'hba, 8'hff);
      rreg(`OFS_MODE_SECOND, 8'h10, 8'hff);
      hreset();
      wreg(`OFS_LDN, `LDN_PARALLEL);
      rreg(`OFS_MODE, 8'h3c, 8'hff);
      rreg(`OFS_MODE_SECOND, 8'h00, 8'hff);
      idle(4);
      end_sim();
   end
endmodule : test_pp_uart_logical_device_config
